// >>> rtl/mcsel_top.v
// Contract
// - Rx partition A field 0..3 selects even block 0,2,4,6.
// - Rx partition fields act only with rx selection on and two-partition mode; tx mode 3 also uses them in tx two-partition mode, whatever the rx settings.
// - A three-bit read field shows the current rx block 0..7.
// - Rx selection off accepts all 128 channels.
// - Rx selection on accepts only channels whose enable bit is set.
// - Rx two-partition mode uses only enable register 0, 32 channels.
// - Bits 0-15 map to partition A block, bits 16-31 to partition B.
// - Rx eight-partition mode: four registers cover channels 0-127 in order.
// - Rx enable bit 0 disables, 1 enables, only while selection is on.
// - Tx partition mode matters only for nonzero tx mode; 32 or 128 channels.
// - Tx two-partition mode uses tx register 0: bits 0-15 A, 16-31 B.
// - Tx eight-partition mode: tx register 0 covers channels 0-31.
// - Rx partition B field 0..3 selects odd block 1,3,5,7.
// - Partition fields rewritable live; current block indicator kept updated.
// - Tx mode: 0 all, 1 selected only, 2 masked unless selected, 3 symmetric.
// - Mode 1 bit enables and unmasks; mode 2 bit only unmasks.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.

`timescale 1ns/10ps
`include "mcsel_regs.vh"
module mcsel_top #(
   parameter ELEM_BITS = `MCSEL_ELEM_BITS
) (
   input wire hclk, // System clock
   input wire hresetn, // Async reset, active low
   input wire clk_en, // Freezes all state when low
   input wire hsel, // Slave select
   input wire [31:0] haddr, // Byte address
   input wire [1:0] htrans, // Transfer type
   input wire hwrite, // Write when high
   input wire [2:0] hsize, // Transfer size, word only
   input wire [31:0] hwdata, // Write data
   input wire hready, // Bus ready
   output reg hreadyout, // Slave ready
   output reg hresp, // Always OKAY
   output reg [31:0] hrdata, // Read data
   input wire rx_bit_clk, // Receive bit clock pin
   input wire rx_frame_sync, // Receive frame sync pin, active high
   input wire tx_bit_clk, // Transmit bit clock pin
   input wire tx_frame_sync, // Transmit frame sync pin, active high
   output reg rx_channel_accept, // Current rx channel is received
   output reg tx_channel_enabled, // Current tx channel is enabled
   output reg tx_channel_unmasked // Current tx channel data may be driven
);

   // Channel select decoder shared by the receive and transmit paths
   function chan_sel;
      input [6:0] chan;
      input eight;
      input [1:0] pa;
      input [1:0] pb;
      input [31:0] r0;
      input [31:0] r1;
      input [31:0] r2;
      input [31:0] r3;
      reg [31:0] word;
      begin
         word = r0;
         chan_sel = 1'b0;
         // Eight partitions: word by channel/32, bit by channel mod 32
         if (eight)
         begin
            case (chan[6:5])
               2'h0: word = r0;
               2'h1: word = r1;
               2'h2: word = r2;
               default: word = r3;
            endcase
            chan_sel = word[chan[4:0]];
         end
         else if (chan[6:4] == {pa, 1'b0})
            chan_sel = r0[{1'b0, chan[3:0]}];
         else if (chan[6:4] == {pb, 1'b1})
            chan_sel = r0[{1'b1, chan[3:0]}];
      end
   endfunction

   // Channel enable banks, four words per direction
   reg [31:0] rce_r [0:3];
   reg [31:0] xce_r [0:3];

   // Writable control fields; current block fields are not stored
   reg rx_on_r, rx_eight_r, tx_eight_r;
   reg [1:0] rx_pa_r, rx_pb_r, tx_pa_r, tx_pb_r, tx_mode_r;

   // Bus pipeline: address phase captured, data phase applied
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   reg [31:0] rd_word;

   // Per-channel decisions ahead of the output flops
   reg rx_sel, tx_rsel, tx_xsel;
   reg tx_en_nxt, tx_um_nxt;
   wire ap_take;
   wire [6:0] rx_chan, tx_chan;

   // Address phase accepted; the one slave never stalls
   assign ap_take = hsel & htrans[1] & hready;

   // Pin synchronisers and channel counters, one per direction
   genvar d;
   generate
      for (d = 0; d < 2; d = d + 1)
      begin : g_dir
         reg [2:0] clk_sync_r;
         reg [1:0] fs_sync_r;
         reg [15:0] bit_cnt_r;
         reg [6:0] chan_r;
         wire pin_clk = (d == 0) ? rx_bit_clk : tx_bit_clk;
         wire pin_fs = (d == 0) ? rx_frame_sync : tx_frame_sync;
         wire edge_w = clk_sync_r[1] & ~clk_sync_r[2];
         // Only stage 1 and later feed logic; stage 0 is metastability guard
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               clk_sync_r <= 3'h0;
               fs_sync_r <= 2'h0;
               bit_cnt_r <= 16'h0000;
               chan_r <= 7'h00;
            end
            else if (clk_en)
            begin
               clk_sync_r <= {clk_sync_r[1:0], pin_clk};
               fs_sync_r <= {fs_sync_r[0], pin_fs};
               if (edge_w)
               begin
                  // Counter holds its channel while the link clock stands still
                  // Frame sync restarts at channel 0; wraps at 128
                  if (fs_sync_r[1])
                  begin
                     bit_cnt_r <= 16'h0000;
                     chan_r <= 7'h00;
                  end
                  else if (bit_cnt_r == ELEM_BITS[15:0] - 16'h0001)
                  begin
                     bit_cnt_r <= 16'h0000;
                     chan_r <= chan_r + 7'h01;
                  end
                  else
                     bit_cnt_r <= bit_cnt_r + 16'h0001;
               end
            end
         end
      end
   endgenerate

   assign rx_chan = g_dir[0].chan_r;
   // Counter views for the decoders and the read mux
   assign tx_chan = g_dir[1].chan_r;

   // Read mux; current block fields come live from the counters
   always @*
   begin
      rd_word = 32'h00000000;
      // Reserved and unmapped bits read as zero
      case (haddr[7:0])
         `MCSEL_OFS_CTRL:
         begin
            rd_word[`MCSEL_TX_EIGHT] = tx_eight_r;
            rd_word[`MCSEL_TX_PB_HI:`MCSEL_TX_PB_LO] = tx_pb_r;
            rd_word[`MCSEL_TX_PA_HI:`MCSEL_TX_PA_LO] = tx_pa_r;
            rd_word[`MCSEL_TX_CB_HI:`MCSEL_TX_CB_LO] = tx_chan[6:4];
            rd_word[`MCSEL_TX_MODE_HI:`MCSEL_TX_MODE_LO] = tx_mode_r;
            rd_word[`MCSEL_RX_EIGHT] = rx_eight_r;
            rd_word[`MCSEL_RX_PB_HI:`MCSEL_RX_PB_LO] = rx_pb_r;
            rd_word[`MCSEL_RX_PA_HI:`MCSEL_RX_PA_LO] = rx_pa_r;
            rd_word[`MCSEL_RX_CB_HI:`MCSEL_RX_CB_LO] = rx_chan[6:4];
            rd_word[`MCSEL_RX_ON] = rx_on_r;
         end
         `MCSEL_OFS_RXEN0: rd_word = rce_r[0];
         `MCSEL_OFS_RXEN1: rd_word = rce_r[1];
         `MCSEL_OFS_RXEN2: rd_word = rce_r[2];
         `MCSEL_OFS_RXEN3: rd_word = rce_r[3];
         `MCSEL_OFS_TXEN0: rd_word = xce_r[0];
         `MCSEL_OFS_TXEN1: rd_word = xce_r[1];
         `MCSEL_OFS_TXEN2: rd_word = xce_r[2];
         `MCSEL_OFS_TXEN3: rd_word = xce_r[3];
         default: rd_word = 32'h00000000;
      endcase
   end

   // Bus slave: zero wait states, writes land in the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rx_on_r <= 1'b0;
         rx_eight_r <= 1'b0;
         tx_eight_r <= 1'b0;
         rx_pa_r <= `MCSEL_RST_CTRL;
         rx_pb_r <= `MCSEL_RST_CTRL;
         tx_pa_r <= `MCSEL_RST_CTRL;
         tx_pb_r <= `MCSEL_RST_CTRL;
         tx_mode_r <= `MCSEL_RST_CTRL;
         rce_r[0] <= `MCSEL_RST_WORD;
         rce_r[1] <= `MCSEL_RST_WORD;
         rce_r[2] <= `MCSEL_RST_WORD;
         rce_r[3] <= `MCSEL_RST_WORD;
         xce_r[0] <= `MCSEL_RST_WORD;
         xce_r[1] <= `MCSEL_RST_WORD;
         xce_r[2] <= `MCSEL_RST_WORD;
         xce_r[3] <= `MCSEL_RST_WORD;
      end
      else if (clk_en)
      begin
         wr_pend_r <= ap_take & hwrite;
         if (ap_take)
            wr_addr_r <= haddr[7:0];
         // Read data loaded at the address phase, stands until the next read
         if (ap_take & ~hwrite)
            hrdata <= rd_word;
         // Partition fields may change mid-frame; the decoder picks them up at once
         if (wr_pend_r)
         begin
            case (wr_addr_r)
               `MCSEL_OFS_CTRL:
               begin
                  tx_eight_r <= hwdata[`MCSEL_TX_EIGHT];
                  tx_pb_r <= hwdata[`MCSEL_TX_PB_HI:`MCSEL_TX_PB_LO];
                  tx_pa_r <= hwdata[`MCSEL_TX_PA_HI:`MCSEL_TX_PA_LO];
                  tx_mode_r <= hwdata[`MCSEL_TX_MODE_HI:`MCSEL_TX_MODE_LO];
                  rx_eight_r <= hwdata[`MCSEL_RX_EIGHT];
                  rx_pb_r <= hwdata[`MCSEL_RX_PB_HI:`MCSEL_RX_PB_LO];
                  rx_pa_r <= hwdata[`MCSEL_RX_PA_HI:`MCSEL_RX_PA_LO];
                  rx_on_r <= hwdata[`MCSEL_RX_ON];
               end
               `MCSEL_OFS_RXEN0: rce_r[0] <= hwdata;
               `MCSEL_OFS_RXEN1: rce_r[1] <= hwdata;
               `MCSEL_OFS_RXEN2: rce_r[2] <= hwdata;
               `MCSEL_OFS_RXEN3: rce_r[3] <= hwdata;
               `MCSEL_OFS_TXEN0: xce_r[0] <= hwdata;
               `MCSEL_OFS_TXEN1: xce_r[1] <= hwdata;
               `MCSEL_OFS_TXEN2: xce_r[2] <= hwdata;
               `MCSEL_OFS_TXEN3: xce_r[3] <= hwdata;
               // Unmapped writes are dropped; the next address capture must survive
               default: ;
            endcase
         end
      end
   end

   // Channel decisions for the channel now on the link
   always @*
   begin
      rx_sel = chan_sel(rx_chan, rx_eight_r, rx_pa_r, rx_pb_r, rce_r[0], rce_r[1], rce_r[2], rce_r[3]);
      // Symmetric mode borrows the rx enables and rx partition fields
      tx_rsel = chan_sel(tx_chan, tx_eight_r, rx_pa_r, rx_pb_r, rce_r[0], rce_r[1], rce_r[2], rce_r[3]);
      if (tx_mode_r == `MCSEL_TXM_SYM)
         tx_xsel = chan_sel(tx_chan, tx_eight_r, rx_pa_r, rx_pb_r, xce_r[0], xce_r[1], xce_r[2], xce_r[3]);
      else
         tx_xsel = chan_sel(tx_chan, tx_eight_r, tx_pa_r, tx_pb_r, xce_r[0], xce_r[1], xce_r[2], xce_r[3]);
      case (tx_mode_r)
         `MCSEL_TXM_ALL:
         begin
            tx_en_nxt = 1'b1;
            tx_um_nxt = 1'b1;
         end
         `MCSEL_TXM_SEL:
         begin
            tx_en_nxt = tx_xsel;
            tx_um_nxt = tx_xsel;
         end
         `MCSEL_TXM_MASK:
         begin
            tx_en_nxt = 1'b1;
            tx_um_nxt = tx_xsel;
         end
         // Symmetric mode: enable from the rx bank, unmask needs both the rx and the tx bank bit
         default:
         begin
            tx_en_nxt = tx_rsel;
            tx_um_nxt = tx_rsel & tx_xsel;
         end
      endcase
   end

   // Outputs registered once per hclk so they track the counters
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         // All registers clear, so every channel is open after reset
         rx_channel_accept <= 1'b1;
         tx_channel_enabled <= 1'b1;
         tx_channel_unmasked <= 1'b1;
      end
      else if (clk_en)
      begin
         // Selection off ignores the enables entirely
         rx_channel_accept <= rx_on_r ? rx_sel : 1'b1;
         // Transmit flags share the same one-cycle lag as receive
         tx_channel_enabled <= tx_en_nxt;
         tx_channel_unmasked <= tx_um_nxt;
      end
   end

endmodule

// >>> include/mcsel_regs.vh
`ifndef MCSEL_REGS_VH
`define MCSEL_REGS_VH
// Register byte offsets
`define MCSEL_OFS_CTRL 8'h00
`define MCSEL_OFS_RXEN0 8'h04
`define MCSEL_OFS_RXEN1 8'h08
`define MCSEL_OFS_RXEN2 8'h0c
`define MCSEL_OFS_RXEN3 8'h10
`define MCSEL_OFS_TXEN0 8'h14
`define MCSEL_OFS_TXEN1 8'h18
`define MCSEL_OFS_TXEN2 8'h1c
`define MCSEL_OFS_TXEN3 8'h20
// Multichannel control field positions
`define MCSEL_TX_EIGHT 25
`define MCSEL_TX_PB_HI 24
`define MCSEL_TX_PB_LO 23
`define MCSEL_TX_PA_HI 22
`define MCSEL_TX_PA_LO 21
`define MCSEL_TX_CB_HI 20
`define MCSEL_TX_CB_LO 18
`define MCSEL_TX_MODE_HI 17
`define MCSEL_TX_MODE_LO 16
`define MCSEL_RX_EIGHT 9
`define MCSEL_RX_PB_HI 8
`define MCSEL_RX_PB_LO 7
`define MCSEL_RX_PA_HI 6
`define MCSEL_RX_PA_LO 5
`define MCSEL_RX_CB_HI 4
`define MCSEL_RX_CB_LO 2
`define MCSEL_RX_ON 0
// Transmit selection modes
`define MCSEL_TXM_ALL 2'h0
`define MCSEL_TXM_SEL 2'h1
`define MCSEL_TXM_MASK 2'h2
`define MCSEL_TXM_SYM 2'h3
// Reset values
`define MCSEL_RST_WORD 32'h00000000
`define MCSEL_RST_CTRL 2'h0
// Default serial element length in bits
`define MCSEL_ELEM_BITS 8
`endif

// >>> test/mcsel_chk.sv
`timescale 1ns/10ps
module mcsel_chk (
   input logic hclk, // Clock
   input logic hresetn, // Reset
   input logic clk_en, // Run
   input logic hsel, // Select
   input logic [31:0] haddr, // Address
   input logic [1:0] htrans, // Type
   input logic hwrite, // Write
   input logic [2:0] hsize, // Size
   input logic [31:0] hwdata, // Wdata
   input logic hready, // Ready in
   input logic hreadyout, // Ready out
   input logic hresp, // Resp
   input logic [31:0] hrdata, // Rdata
   input logic rx_bit_clk, // Rx clock
   input logic rx_frame_sync, // Rx sync
   input logic tx_bit_clk, // Tx clock
   input logic tx_frame_sync, // Tx sync
   input logic rx_channel_accept, // Rx taken
   input logic tx_channel_enabled, // Tx enabled
   input logic tx_channel_unmasked // Tx unmasked
);
   logic wp_r;
   logic [3:0] wi_r;
   logic [31:0] sh [9];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Shadow of written words; lands at data phase end like the design
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wp_r <= 1'b0;
         wi_r <= 4'h0;
         for (int i = 0; i < 9; i++)
            sh[i] <= 32'h0;
      end
      else
      begin
         wp_r <= clk_en && hsel && htrans[1] && hwrite && hready && haddr[7:0] < 8'h24;
         wi_r <= haddr[5:2];
         if (wp_r && clk_en) sh[wi_r] <= hwdata;
      end
   end
   // Three stable cycles cover the one-cycle output lag
   wire [1:0] txm = sh[0][17:16];
   wire rx_none = ~|{sh[1], sh[2], sh[3], sh[4]};
   wire tx_none = ~|{sh[5], sh[6], sh[7], sh[8]};
   wire tx_full = &{sh[5], sh[6], sh[7], sh[8]};
   property p_rx_all;
      (!sh[0][0]) [*3] |-> rx_channel_accept;
   endproperty
   a_rx_all: assert property (p_rx_all) else $error("rx refused with selection off");
   property p_rx_none;
      (sh[0][0] && rx_none) [*3] |-> !rx_channel_accept;
   endproperty
   a_rx_none: assert property (p_rx_none) else $error("rx taken with no enable");
   property p_tx_m0;
      (txm == 2'h0) [*3] |-> tx_channel_enabled && tx_channel_unmasked;
   endproperty
   a_tx_m0: assert property (p_tx_m0) else $error("tx blocked in mode 0");
   property p_tx_m1;
      (txm == 2'h1) [*3] |-> tx_channel_enabled == tx_channel_unmasked;
   endproperty
   a_tx_m1: assert property (p_tx_m1) else $error("tx mode 1 enable and mask differ");
   property p_tx_m2;
      (txm == 2'h2) [*3] |-> tx_channel_enabled;
   endproperty
   a_tx_m2: assert property (p_tx_m2) else $error("tx disabled in mode 2");
   property p_tx_m3;
      (txm == 2'h3) [*3] |-> !tx_channel_unmasked || tx_channel_enabled;
   endproperty
   a_tx_m3: assert property (p_tx_m3) else $error("tx unmasked while disabled");
   property p_tx_none;
      (txm == 2'h1 && tx_none) [*3] |-> !tx_channel_enabled;
   endproperty
   a_tx_none: assert property (p_tx_none) else $error("tx enabled with no bit set");
   property p_tx_full;
      (txm == 2'h1 && tx_full) [*3] |-> tx_channel_enabled && tx_channel_unmasked;
   endproperty
   a_tx_full: assert property (p_tx_full) else $error("tx blocked with all bits set");
endmodule
bind mcsel_top mcsel_chk chk_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
   .hready, .hreadyout, .hresp, .hrdata, .rx_bit_clk, .rx_frame_sync, .tx_bit_clk, .tx_frame_sync,
   .rx_channel_accept, .tx_channel_enabled, .tx_channel_unmasked);

// >>> test/mcsel_peer.sv
`timescale 1ns/10ps
// Frame peer; its bit clock stands still between frames
module mcsel_peer #(
   parameter int BITS = 1024
) (
   output logic bit_clk, // Link bit clock
   output logic frame_sync // Frame start, high
);
   initial
   begin
      bit_clk = 1'b0;
      frame_sync = 1'b0;
   end
   // Sync stays high across the first rising edge only
   task automatic frame;
      begin
         // Small offset keeps every pin change clear of the system clock edges
         #2;
         frame_sync = 1'b1;
         repeat (BITS)
         begin
            #62.5 bit_clk = 1'b1;
            #62.5 bit_clk = 1'b0;
            frame_sync = 1'b0;
         end
      end
   endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, v;
   logic hreadyout, hresp, acc, en, um, bclk, fs;
   logic cnt_on = 1'b0;
   int err_count = 0, compares = 0, acc_n, en_n, um_n, tn = 0;
   always #5 hclk = ~hclk;
   mcsel_peer peer_u (.bit_clk(bclk), .frame_sync(fs));
   mcsel_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rx_bit_clk(bclk), .rx_frame_sync(fs), .tx_bit_clk(bclk), .tx_frame_sync(fs),
      .rx_channel_accept(acc), .tx_channel_enabled(en), .tx_channel_unmasked(um));
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      begin
         compares++;
         if (seen !== exp)
         begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("compares %0d mismatches %0d", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Bounded wait for ready sampled at a rising edge
   task wt;
      int n;
      begin
         n = 0;
         @(posedge hclk);
         while (hreadyout !== 1'b1 && n < 20)
         begin
            n++;
            @(posedge hclk);
         end
         if (n >= 20)
         begin
            err_count++;
            report_and_stop;
         end
      end
   endtask
   // One single word transfer; read data lands in v
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      begin
         hsel <= 1'b1;
         haddr <= {24'h0, a};
         htrans <= 2'h2;
         hwrite <= w;
         wt;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         wt;
         v = hrdata;
         chk({31'h0, hresp}, 32'h0, "response");
      end
   endtask
   // Cycles per channel are 100, so counts round to channels
   always @(posedge hclk)
      if (cnt_on)
      begin
         acc_n += acc;
         en_n += en;
         um_n += um;
      end
   task frame(input int ea, input int ee, input int eu);
      begin
         acc_n = 0;
         en_n = 0;
         um_n = 0;
         cnt_on <= 1'b1;
         peer_u.frame;
         cnt_on <= 1'b0;
         chk(32'((acc_n + 50) / 100), 32'(ea), "rx channels");
         chk(32'((en_n + 50) / 100), 32'(ee), "tx enabled");
         chk(32'((um_n + 50) / 100), 32'(eu), "tx unmasked");
         tn++;
         $display("frame test %0d done", tn);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         bus(8'(i * 4), 1'b0, 32'h0);
         chk(v, 32'h0, "reset value");
      end
      bus(8'h00, 1'b1, 32'hffffffff);
      bus(8'h24, 1'b1, 32'hffffffff);
      bus(8'h00, 1'b0, 32'h0);
      chk(v, 32'h03e303e1, "control readback");
      bus(8'h24, 1'b0, 32'h0);
      chk(v, 32'h0, "unmapped read");
      $display("register test done");
      bus(8'h00, 1'b1, 32'h0);
      frame(128, 128, 128);
      bus(8'h00, 1'b0, 32'h0);
      chk(v, 32'h001c001c, "current block");
      bus(8'h00, 1'b1, 32'h00010121);
      bus(8'h04, 1'b1, 32'h00030006);
      bus(8'h08, 1'b1, 32'hffffffff);
      bus(8'h10, 1'b1, 32'h00000001);
      bus(8'h14, 1'b1, 32'h00020002);
      frame(4, 2, 2);
      bus(8'h00, 1'b1, 32'h02020321);
      frame(37, 128, 2);
      bus(8'h00, 1'b1, 32'h02030320);
      frame(128, 37, 2);
      for (int i = 5; i < 9; i++)
         bus(8'(i * 4), 1'b1, 32'hffffffff);
      bus(8'h00, 1'b1, 32'h02010000);
      frame(128, 128, 128);
      report_and_stop;
   end
endmodule
